// *** serial_host_port_consts.svh ***
// Constants for the serial host port select and request logic.
// Assumes a 100 MHz sys_clk; the NS constants are in ns, SCK_HALF_CYCLES is in sys_clk cycles.
`ifndef SERIAL_HOST_PORT_CONSTS_SVH
`define SERIAL_HOST_PORT_CONSTS_SVH

`define SYS_CLK_PERIOD_NS   10
`define SCK_HALF_NS         40
`define SCK_HALF_CYCLES     ((`SCK_HALF_NS + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS)
`define WORD_BITS           8
`define BIT_CNT_LAST        3'h7
`define SYNC_PIN_COUNT      6
// Synchroniser reset levels follow each pin's idle level; the clock idles low
`define SYNC_RESET          6'h2F
`define RX_DEPTH            2
`define REQ_MODE_OFF        2'h0
`define I2C_ADDR_UPPER      4'h5
`define I2C_ADDR_LOWER      2'h0
`define SHIFT_RESET         8'h00

`endif

// *** serial_host_port_pkg.sv ***
// Types shared by the serial host port select and request logic.
// Assumes the constants header is compiled alongside.
package serial_host_port_pkg;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_SHIFT = 2'b01
	} state_type;

	// Synchronised pin inputs, in the order of the synchroniser vector
	typedef struct packed {
		logic ss_n;
		logic sck;
		logic mosi;
		logic miso;
		logic host_request_n;
		logic i2c_addr_bit2_pin;
	} pin_in_type;

	typedef struct packed {
		logic       spi_mode;
		logic       master_mode;
		logic [1:0] request_mode_field;
	} port_cfg_type;

endpackage

// *** serial_host_port.sv ***
// Slave select, host request and word transfer control for the serial host port.
// Assumes pins arrive asynchronous to sys_clk; cfg and user-side signals are sys_clk logic.
//
// Function
// - In SPI slave mode a transfer only takes place while the active-low select is low.
// - Select seen low while configured as SPI master sets a bus error flag.
// - With select high, clock edges are ignored and the slave data output is not driven.
// - The address bit 2 pin forms part of the own address in I2C slave mode only.
// - Host request is an active-low input in master mode and an active-low output in slave mode.
// - In slave mode host request goes low when ready for a word and high at that word's first clock.
// - In master mode a low host request from the slave starts the next word.
// - In master mode each further word waits for a fresh assertion of host request.
// - Host request is not driven during reset or while the request mode field is zero.
// - The address bit 2 pin is never driven, so it floats during every reset.
// - The slave data line is an output in SPI slave mode and the data input in SPI master mode.
`include "serial_host_port_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module serial_host_port (
	input  wire logic                                sys_clk,
	input  wire logic                                resetn,
	input  wire logic                                port_reset,
	input  wire serial_host_port_pkg::port_cfg_type  cfg,
	input  wire logic                                bus_error_clear,
	input  wire serial_host_port_pkg::pin_in_type    pin_in,
	output var  logic                                miso_out,
	output var  logic                                miso_oe,
	output var  logic                                mosi_out,
	output var  logic                                mosi_oe,
	output var  logic                                sck_out,
	output var  logic                                sck_oe,
	output var  logic                                host_request_n_out,
	output var  logic                                host_request_n_oe,
	output var  logic                                i2c_addr_bit2_pin_oe,
	output var  logic [6:0]                          i2c_own_addr,
	output var  logic                                bus_error,
	input  wire logic [`WORD_BITS-1:0]               tx_data,
	input  wire logic                                tx_valid,
	output var  logic                                tx_ready,
	output var  logic [`WORD_BITS-1:0]               rx_data,
	output var  logic                                rx_valid,
	input  wire logic                                rx_ready
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [`SYNC_PIN_COUNT-1:0] meta_q;
	logic [`SYNC_PIN_COUNT-1:0] sync_q;
	serial_host_port_pkg::pin_in_type pin_s;
	localparam logic [`SYNC_PIN_COUNT-1:0] sync_reset_value = `SYNC_RESET;

	genvar gi;
	generate
		for (gi = 0; gi < `SYNC_PIN_COUNT; gi = gi + 1) begin : g_sync
			always_ff @(posedge sys_clk or negedge resetn) begin
				if (!resetn) begin
					meta_q[gi] <= sync_reset_value[gi];
					sync_q[gi] <= sync_reset_value[gi];
				end else begin
					meta_q[gi] <= pin_in[gi];
					sync_q[gi] <= meta_q[gi];
				end
			end
		end
	endgenerate

	assign pin_s = serial_host_port_pkg::pin_in_type'(sync_q);

	// ----------------------------------------------------------------
	// Mode decode and clock edges
	// ----------------------------------------------------------------
	logic sck_prev_q;
	logic sck_rise;
	logic sck_fall;
	logic spi_slave;
	logic spi_master;
	logic slave_sel;

	assign spi_slave  = cfg.spi_mode & ~cfg.master_mode & ~port_reset;
	assign spi_master = cfg.spi_mode & cfg.master_mode & ~port_reset;
	assign slave_sel  = spi_slave & ~pin_s.ss_n;
	assign sck_rise   = pin_s.sck & ~sck_prev_q;
	assign sck_fall   = ~pin_s.sck & sck_prev_q;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			sck_prev_q <= 1'b0;
		end else begin
			sck_prev_q <= pin_s.sck;
		end
	end

	// ----------------------------------------------------------------
	// Bus error flag
	// ----------------------------------------------------------------
	logic bus_error_q;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			bus_error_q <= 1'b0;
		end else if (spi_master && !pin_s.ss_n) begin
			bus_error_q <= 1'b1;
		end else if (bus_error_clear || port_reset) begin
			bus_error_q <= 1'b0;
		end
	end

	assign bus_error = bus_error_q;

	// ----------------------------------------------------------------
	// I2C own address
	// ----------------------------------------------------------------
	logic [6:0] own_addr_q;
	logic       addr_oe_q;

	// pin used in slave mode, held value in master mode
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			own_addr_q <= {`I2C_ADDR_UPPER, 1'b0, `I2C_ADDR_LOWER};
		end else if (!cfg.spi_mode && !cfg.master_mode) begin
			own_addr_q <= {`I2C_ADDR_UPPER, pin_s.i2c_addr_bit2_pin, `I2C_ADDR_LOWER};
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			addr_oe_q <= 1'b0;
		end else begin
			addr_oe_q <= 1'b0;
		end
	end

	assign i2c_own_addr         = own_addr_q;
	assign i2c_addr_bit2_pin_oe = addr_oe_q;

	// ----------------------------------------------------------------
	// Transmit holding word
	// ----------------------------------------------------------------
	logic [`WORD_BITS-1:0] tx_word_q;
	logic                  tx_empty_q;
	logic                  tx_take;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			tx_empty_q <= 1'b1;
			tx_word_q  <= `SHIFT_RESET;
		end else if (port_reset) begin
			tx_empty_q <= 1'b1;
		end else if (tx_take) begin
			tx_empty_q <= 1'b1;
		end else if (tx_empty_q && tx_valid) begin
			tx_empty_q <= 1'b0;
			tx_word_q  <= tx_data;
		end
	end

	assign tx_ready = tx_empty_q;

	// ----------------------------------------------------------------
	// Receive buffer, two entries, head in slot 0
	// ----------------------------------------------------------------
	logic [`WORD_BITS-1:0] rx_mem_q [`RX_DEPTH];
	logic [`RX_DEPTH-1:0]  rx_occ_q;
	logic                  rx_push;
	logic                  rx_pop;
	logic                  rx_space;
	logic [`WORD_BITS-1:0] rx_word;

	assign rx_pop   = rx_occ_q[0] & rx_ready;
	// Stalls the start of a master-mode word so a slow reader never loses one; a slave word into a full buffer overwrites slot 1
	assign rx_space = ~rx_occ_q[1];

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rx_occ_q    <= 2'h0;
			rx_mem_q[0] <= `SHIFT_RESET;
			rx_mem_q[1] <= `SHIFT_RESET;
		end else if (port_reset) begin
			rx_occ_q <= 2'h0;
		end else begin
			if (rx_pop) begin
				rx_mem_q[0] <= rx_mem_q[1];
			end
			case ({rx_push, rx_pop})
				2'b10: begin
					rx_occ_q <= {rx_occ_q[0], 1'b1};
					if (rx_occ_q[0]) begin
						rx_mem_q[1] <= rx_word;
					end else begin
						rx_mem_q[0] <= rx_word;
					end
				end
				2'b01: rx_occ_q <= {1'b0, rx_occ_q[1]};
				2'b11: begin
					if (rx_occ_q[1]) begin
						rx_mem_q[1] <= rx_word;
					end else begin
						rx_mem_q[0] <= rx_word;
					end
				end
				default: rx_occ_q <= rx_occ_q;
			endcase
		end
	end

	assign rx_data  = rx_mem_q[0];
	assign rx_valid = rx_occ_q[0];

	// ----------------------------------------------------------------
	// Shift engine
	// ----------------------------------------------------------------
	serial_host_port_pkg::state_type state_q;
	logic [`WORD_BITS-1:0] sh_q;
	logic [2:0]            bit_cnt_q;
	logic [2:0]            div_q;
	logic                  req_armed_q;
	logic                  miso_q;
	logic                  mosi_q;
	logic                  sck_q;
	logic                  word_ready;
	logic                  master_start;
	logic                  div_tick;
	logic                  slave_last;
	logic                  master_last;

	assign word_ready   = ~tx_empty_q & rx_space;
	// start only on a fresh low request
	assign master_start = spi_master & word_ready & req_armed_q & ~pin_s.host_request_n;
	assign div_tick     = (div_q == 3'(`SCK_HALF_CYCLES - 1));
	assign slave_last   = slave_sel & sck_rise & (bit_cnt_q == `BIT_CNT_LAST);
	assign master_last  = spi_master & div_tick & ~sck_q & (bit_cnt_q == `BIT_CNT_LAST);
	// data in from mosi as slave, from miso as master
	assign rx_word      = spi_master ? {sh_q[6:0], pin_s.miso} : {sh_q[6:0], pin_s.mosi};
	assign rx_push      = (state_q == serial_host_port_pkg::ST_SHIFT) & (slave_last | master_last);
	assign tx_take      = (slave_sel & (state_q == serial_host_port_pkg::ST_IDLE) & word_ready)
	                    | (slave_last & word_ready) | master_start;

	// re-armed only after request is seen high
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			req_armed_q <= 1'b0;
		end else if (master_start || !spi_master) begin
			req_armed_q <= 1'b0;
		end else if (pin_s.host_request_n && state_q == serial_host_port_pkg::ST_IDLE) begin
			req_armed_q <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state_q   <= serial_host_port_pkg::ST_IDLE;
			sh_q      <= `SHIFT_RESET;
			bit_cnt_q <= 3'h0;
			div_q     <= 3'h0;
			sck_q     <= 1'b0;
			mosi_q    <= 1'b0;
			miso_q    <= 1'b0;
		end else if (spi_master) begin
			case (state_q)
				serial_host_port_pkg::ST_IDLE: begin
					sck_q <= 1'b0;
					div_q <= 3'h0;
					if (master_start) begin
						sh_q      <= tx_word_q;
						mosi_q    <= tx_word_q[7];
						bit_cnt_q <= 3'h0;
						state_q   <= serial_host_port_pkg::ST_SHIFT;
					end
				end
				default: begin
					div_q <= div_tick ? 3'h0 : div_q + 3'h1;
					if (div_tick) begin
						sck_q <= ~sck_q;
						if (!sck_q) begin
							sh_q      <= rx_word;
							bit_cnt_q <= bit_cnt_q + 3'h1;
							if (master_last) begin
								state_q <= serial_host_port_pkg::ST_IDLE;
							end
						end else begin
							mosi_q <= sh_q[7];
						end
					end
				end
			endcase
		end else if (!slave_sel) begin
			state_q   <= serial_host_port_pkg::ST_IDLE;
			bit_cnt_q <= 3'h0;
			sck_q     <= 1'b0;
		end else begin
			case (state_q)
				serial_host_port_pkg::ST_IDLE: begin
					sh_q    <= word_ready ? tx_word_q : `SHIFT_RESET;
					miso_q  <= word_ready ? tx_word_q[7] : 1'b0;
					state_q <= serial_host_port_pkg::ST_SHIFT;
				end
				default: begin
					if (sck_rise) begin
						bit_cnt_q <= bit_cnt_q + 3'h1;
						sh_q      <= slave_last ? (word_ready ? tx_word_q : `SHIFT_RESET) : rx_word;
					end else if (sck_fall) begin
						miso_q <= sh_q[7];
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Pin drivers
	// ----------------------------------------------------------------
	logic miso_oe_q;
	logic mosi_oe_q;
	logic sck_oe_q;
	logic req_n_q;
	logic req_oe_q;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			miso_oe_q <= 1'b0;
			mosi_oe_q <= 1'b0;
			sck_oe_q  <= 1'b0;
		end else begin
			miso_oe_q <= slave_sel;
			mosi_oe_q <= spi_master;
			sck_oe_q  <= spi_master;
		end
	end

	// driven only as slave with a nonzero request mode
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			req_oe_q <= 1'b0;
		end else begin
			req_oe_q <= ~port_reset & ~cfg.master_mode & (cfg.request_mode_field != `REQ_MODE_OFF);
		end
	end

	// low when ready, high at the first clock of the word
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			req_n_q <= 1'b1;
		end else if (port_reset || cfg.master_mode) begin
			req_n_q <= 1'b1;
		end else if (slave_sel && sck_rise && bit_cnt_q == 3'h0) begin
			req_n_q <= 1'b1;
		end else if (word_ready && bit_cnt_q == 3'h0 && !sck_rise) begin
			req_n_q <= 1'b0;
		end
	end

	assign miso_out           = miso_q;
	assign miso_oe            = miso_oe_q;
	assign mosi_out           = mosi_q;
	assign mosi_oe            = mosi_oe_q;
	assign sck_out            = sck_q;
	assign sck_oe             = sck_oe_q;
	assign host_request_n_out = req_n_q;
	assign host_request_n_oe  = req_oe_q;

endmodule // serial_host_port

`default_nettype wire

// *** serial_host_port_checker.sv ***
// Assertions on select, request, address and error pins of the serial host port.
// Assumes a bind to serial_host_port; pins reach its logic through two-flop synchronisers.
`include "serial_host_port_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module serial_host_port_checker (
	input wire logic                               sys_clk,
	input wire logic                               resetn,
	input wire logic                               port_reset,
	input wire serial_host_port_pkg::port_cfg_type cfg,
	input wire logic                               bus_error_clear,
	input wire serial_host_port_pkg::pin_in_type   pin_in,
	input wire logic                               miso_oe,
	input wire logic                               host_request_n_out,
	input wire logic                               host_request_n_oe,
	input wire logic                               i2c_addr_bit2_pin_oe,
	input wire logic [6:0]                         i2c_own_addr,
	input wire logic                               bus_error
);
	// ----------
	// Properties
	// ----------
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	// Repetition counts leave room for the synchroniser and the output register
	property p_miso_idle; pin_in.ss_n [*6] |-> !miso_oe; endproperty
	a_miso_idle: assert property (p_miso_idle) else $error("miso driven with select idle");
	property p_miso_master; cfg.master_mode [*3] |-> !miso_oe; endproperty
	a_miso_master: assert property (p_miso_master) else $error("miso driven in master mode");
	property p_berr_set; (cfg.spi_mode && cfg.master_mode && !pin_in.ss_n) [*2] |-> ##[1:4] bus_error; endproperty
	a_berr_set: assert property (p_berr_set) else $error("select conflict not flagged");
	property p_berr_hold; bus_error && !bus_error_clear && !port_reset |=> bus_error; endproperty
	a_berr_hold: assert property (p_berr_hold) else $error("bus error dropped by itself");
	property p_berr_clr; pin_in.ss_n [*5] ##0 bus_error_clear |=> !bus_error; endproperty
	a_berr_clr: assert property (p_berr_clr) else $error("bus error not cleared");
	property p_req_off; (cfg.request_mode_field == `REQ_MODE_OFF) [*2] |-> !host_request_n_oe; endproperty
	a_req_off: assert property (p_req_off) else $error("request driven with mode off");
	property p_preset; port_reset |=> !host_request_n_oe && !miso_oe && !i2c_addr_bit2_pin_oe; endproperty
	a_preset: assert property (p_preset) else $error("pin driven in port reset");
	property p_req_master; cfg.master_mode [*2] |-> !host_request_n_oe; endproperty
	a_req_master: assert property (p_req_master) else $error("request driven in master mode");
	property p_req_drop;
		!cfg.master_mode && host_request_n_oe && !host_request_n_out && !pin_in.ss_n && $rose(pin_in.sck)
			|-> ##[1:6] host_request_n_out;
	endproperty
	a_req_drop: assert property (p_req_drop) else $error("request kept at word start");
	property p_addr;
		(!cfg.spi_mode && !cfg.master_mode && $stable(pin_in.i2c_addr_bit2_pin)) [*6]
			|-> i2c_own_addr == {`I2C_ADDR_UPPER, pin_in.i2c_addr_bit2_pin, `I2C_ADDR_LOWER};
	endproperty
	a_addr: assert property (p_addr) else $error("own address ignores pin");
	property p_addr_hold; cfg.master_mode [*4] |=> $stable(i2c_own_addr); endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("own address moved in master mode");
	c_berr: cover property (bus_error);
	c_req: cover property (host_request_n_oe && !host_request_n_out);
	c_miso: cover property (miso_oe);
endmodule // serial_host_port_checker

`default_nettype wire

// *** spi_far_end.sv ***
// Far-side party: SPI master towards a slave port, SPI slave towards a master port.
// Assumes the bench resolves every shared line and feeds the result back here.
`timescale 1ns/1ns
`default_nettype none

module spi_far_end (
	input  wire logic       far_master,
	input  wire logic       sck_w,
	input  wire logic       mosi_w,
	input  wire logic       miso_w,
	input  wire logic       req_w,
	output var  logic       ss_n,
	output var  logic       sck,
	output wire logic       sdo,
	output var  logic       req_n,
	output var  logic [7:0] got,
	output var  logic       req_first,
	output var  logic       req_second
);
	logic [7:0] sh;

	initial begin
		ss_n = 1'b1;
		sck = 1'b0;
		req_n = 1'b1;
		sh = 8'h00;
	end
	assign sdo = sh[7];
	// One shifter serves both roles: sample on rise, move on fall
	always @(posedge sck_w) got <= {got[6:0], far_master ? miso_w : mosi_w};
	always @(negedge sck_w) sh <= {sh[6:0], 1'b0};
	task automatic select(input logic v);
		ss_n = v;
	endtask
	task automatic offer(input logic [7:0] d);
		sh = d;
		req_n = 1'b0;
	endtask
	task automatic withdraw();
		req_n = 1'b1;
	endtask
	// Clock stands still outside frames; 125 ns per bit
	task automatic frame(input logic [7:0] d, input logic with_sel);
		sh = d;
		ss_n = !with_sel;
		#200 req_first = req_w;
		for (int i = 0; i < 8; i++) begin
			#62 sck = 1'b1;
			#63 sck = 1'b0;
			if (i == 1) req_second = req_w;
		end
		#200 ss_n = 1'b1;
		#200;
	endtask
endmodule // spi_far_end

`default_nettype wire

// *** serial_host_port_bench.sv ***
// Self-checking bench for the serial host port select and request logic.
// Assumes the package, the far-side model and the checker are compiled before it.
`include "serial_host_port_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module serial_host_port_bench;
	logic                               sys_clk = 1'b0;
	logic                               resetn = 1'b0;
	logic                               port_reset = 1'b0;
	logic                               bus_error_clear = 1'b0;
	logic                               tx_valid = 1'b0;
	logic                               rx_ready = 1'b0;
	logic                               addr2 = 1'b0;
	logic                               und = 1'b0;
	logic [7:0]                         tx_data = 8'h00;
	serial_host_port_pkg::port_cfg_type cfg = 4'h0;
	serial_host_port_pkg::pin_in_type   pin_in;
	logic                               miso_out, miso_oe, mosi_out, mosi_oe, sck_out, sck_oe;
	logic                               hr_out, hr_oe, a2_oe, bus_error, tx_ready, rx_valid;
	logic [6:0]                         own;
	logic [7:0]                         rx_data, got;
	logic                               m_ss, m_sck, m_sdo, m_req, r0, r1;
	int                                 n_errors = 0;
	int                                 comparisons = 0;
	// Released lines show a pattern that changes every cycle, never a held value
	wire logic sck_w = sck_oe ? sck_out : m_sck;
	wire logic miso_w = miso_oe ? miso_out : (cfg.master_mode ? m_sdo : und);
	wire logic mosi_w = mosi_oe ? mosi_out : (cfg.master_mode ? und : m_sdo);
	wire logic req_w = hr_oe ? hr_out : (cfg.master_mode ? m_req : und);

	always #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) und <= ~und;
	assign pin_in = {m_ss, sck_w, mosi_w, miso_w, req_w, addr2};

	serial_host_port uut (.sys_clk(sys_clk), .resetn(resetn), .port_reset(port_reset), .cfg(cfg),
		.bus_error_clear(bus_error_clear), .pin_in(pin_in), .miso_out(miso_out), .miso_oe(miso_oe),
		.mosi_out(mosi_out), .mosi_oe(mosi_oe), .sck_out(sck_out), .sck_oe(sck_oe), .host_request_n_out(hr_out),
		.host_request_n_oe(hr_oe), .i2c_addr_bit2_pin_oe(a2_oe), .i2c_own_addr(own), .bus_error(bus_error),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
		.rx_ready(rx_ready));
	spi_far_end m (.far_master(!cfg.master_mode), .sck_w(sck_w), .mosi_w(mosi_w), .miso_w(miso_w), .req_w(req_w),
		.ss_n(m_ss), .sck(m_sck), .sdo(m_sdo), .req_n(m_req), .got(got), .req_first(r0), .req_second(r1));

	// -------------
	// Shared tasks
	// -------------
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic push(input logic [7:0] d);
		cyc(1);
		for (int i = 0; i < 300 && tx_ready !== 1'b1; i++) cyc(1);
		if (tx_ready !== 1'b1) n_errors++;
		tx_data = d;
		tx_valid = 1'b1;
		cyc(1);
		tx_valid = 1'b0;
	endtask
	task automatic pop(input logic [7:0] e);
		cyc(1);
		for (int i = 0; i < 500 && rx_valid !== 1'b1; i++) cyc(1);
		if (rx_valid !== 1'b1) n_errors++;
		chk("rx_data", e, rx_data);
		rx_ready = 1'b1;
		cyc(1);
		rx_ready = 1'b0;
	endtask
	task automatic end_of_test();
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ---------
	// Scenarios
	// ---------
	task automatic t_reset();
		chk("oe", 8'h00, 8'({miso_oe, mosi_oe, sck_oe, hr_oe, a2_oe}));
		chk("req_out", 8'h01, 8'(hr_out));
		chk("own_addr", 8'({`I2C_ADDR_UPPER, 1'b0, `I2C_ADDR_LOWER}), 8'(own));
		chk("flags", 8'h04, 8'({tx_ready, rx_valid, bus_error}));
	endtask
	task automatic t_slave();
		cfg = 4'h9; // SPI slave, request mode 1
		push(8'hA5);
		m.frame(8'h3C, 1'b1);
		chk("miso_word", 8'hA5, got);
		chk("req_ready", 8'h00, 8'(r0));
		chk("req_taken", 8'h01, 8'(r1));
		push(8'h5A);
		m.frame(8'hC3, 1'b1);
		chk("miso_word", 8'h5A, got);
		push(8'h0F);
		cyc(20);
		chk("req_full", 8'h01, 8'(hr_out));
		pop(8'h3C);
		pop(8'hC3);
		m.frame(8'h77, 1'b0);
		cyc(2);
		chk("rx_valid", 8'h00, 8'(rx_valid));
		chk("miso_oe", 8'h00, 8'(miso_oe));
		chk("req_oe", 8'h01, 8'(hr_oe));
		port_reset = 1'b1;
		cyc(1);
		chk("oe", 8'h00, 8'({miso_oe, hr_oe, a2_oe}));
		port_reset = 1'b0;
	endtask
	task automatic t_master();
		cfg = 4'hD; // SPI master, request mode 1
		cyc(10);
		push(8'h96);
		m.offer(8'h69);
		pop(8'h69);
		chk("mosi_word", 8'h96, got);
		push(8'hE1);
		cyc(150);
		chk("no_fresh", 8'h00, 8'(rx_valid));
		m.withdraw();
		cyc(20);
		m.offer(8'h1E);
		pop(8'h1E);
		chk("mosi_word", 8'hE1, got);
		m.withdraw();
	endtask
	task automatic t_berr();
		m.select(1'b0);
		cyc(6);
		chk("bus_error", 8'h01, 8'(bus_error));
		chk("miso_oe", 8'h00, 8'(miso_oe));
		m.select(1'b1);
		cyc(10);
		chk("bus_error", 8'h01, 8'(bus_error));
		bus_error_clear = 1'b1;
		cyc(1);
		bus_error_clear = 1'b0;
		cyc(1);
		chk("bus_error", 8'h00, 8'(bus_error));
	endtask
	task automatic t_i2c();
		cfg = 4'h0; // I2C slave, request mode off
		addr2 = 1'b1;
		cyc(10);
		chk("own_addr", 8'({`I2C_ADDR_UPPER, 1'b1, `I2C_ADDR_LOWER}), 8'(own));
		chk("req_oe", 8'h00, 8'(hr_oe));
		cfg = 4'h4; // I2C master
		cyc(5);
		addr2 = 1'b0;
		cyc(10);
		chk("own_addr", 8'({`I2C_ADDR_UPPER, 1'b1, `I2C_ADDR_LOWER}), 8'(own));
	endtask

	initial begin
		cyc(19);
		t_reset();
		cyc(1);
		resetn = 1'b1;
		t_slave();
		t_master();
		t_berr();
		t_i2c();
		end_of_test();
	end
	// Whole run needs well under 10000 cycles
	initial begin
		#200000;
		n_errors++;
		end_of_test();
	end
endmodule // serial_host_port_bench

bind serial_host_port serial_host_port_checker chk_i (.sys_clk(sys_clk), .resetn(resetn), .port_reset(port_reset),
	.cfg(cfg), .bus_error_clear(bus_error_clear), .pin_in(pin_in), .miso_oe(miso_oe),
	.host_request_n_out(host_request_n_out), .host_request_n_oe(host_request_n_oe),
	.i2c_addr_bit2_pin_oe(i2c_addr_bit2_pin_oe), .i2c_own_addr(i2c_own_addr), .bus_error(bus_error));

`default_nettype wire
